//--- rtl/sio_pkg.sv
`default_nettype none
// ============================================================
// shared constants of the bus i/o instruction unit
package sio_pkg;
	// ============================================================
	// timing
	localparam int CLK_PERIOD_NS   = 25;                       // core clock period
	localparam int BUS_FREE_NS     = 400;                      // least bus free delay
	localparam int ARB_DELAY_NS    = 2400;                     // least arbitration delay
	localparam int SEL_SETTLE_NS   = 100;                      // hold of bsy after win
	localparam logic [7:0] BUS_FREE_CYC =
		8'((BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] ARB_CYC =
		8'((ARB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] SETTLE_CYC =
		8'((SEL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ============================================================
	// register byte offsets
	localparam logic [7:0] OFS_CMD    = 8'h00;                // byte_count_register (word 1)
	localparam logic [7:0] OFS_NXT    = 8'h04;                // next_address_register (word 2)
	localparam logic [7:0] OFS_IP     = 8'h08;                // instruction pointer
	localparam logic [7:0] OFS_DSA    = 8'h0c;                // data_structure_base_register
	localparam logic [7:0] OFS_OWNID  = 8'h10;                // own_bus_id_register
	localparam logic [7:0] OFS_SYNC_TRANSFER_REGISTER  = 8'h14;                // sync_transfer_register
	localparam logic [7:0] OFS_CTL0   = 8'h18;                // bus_control_register_zero
	localparam logic [7:0] OFS_LATCH  = 8'h1c;                // bus_output_control_latch
	localparam logic [7:0] OFS_INTERRUPT_STATUS_REGISTER  = 8'h20;                // interrupt_status_register
	localparam logic [7:0] OFS_EXEC   = 8'h24;                // go / execution status

	// ============================================================
	// field positions
	localparam int CMD_TYPE_HI   = 31;                         // instruction type 31:30
	localparam int CMD_OPC_HI    = 29;                         // opcode 29:27
	localparam int CMD_OPC_LO    = 27;
	localparam int CMD_REL_BIT   = 26;                         // relative addressing
	localparam int CMD_TBL_BIT   = 25;                         // table indirect
	localparam int CMD_SATN_BIT  = 24;                         // select with attention
	localparam int CMD_CARRY_BIT = 10;
	localparam int CMD_TGT_BIT   = 9;
	localparam int CMD_ACK_BIT   = 6;
	localparam int CMD_ATN_BIT   = 3;
	localparam int LATCH_ATN_BIT = 3;
	localparam int LATCH_ACK_BIT = 6;
	localparam int CTL0_TGT_BIT  = 0;
	localparam int INTERRUPT_STATUS_REGISTER_SIGNAL_PROCESS_FLAG_BIT = 5;
	localparam int EXEC_GO_BIT   = 0;
	localparam int EXEC_DONE_BIT = 0;
	localparam int EXEC_RW_BIT   = 1;
	localparam int EXEC_ILL_BIT  = 2;
	localparam int EXEC_BUSY_BIT = 3;
	localparam int EXEC_CARRY_BIT = 4;
	localparam logic [1:0] TYPE_IO = 2'h1;                     // i/o class type code

	// ============================================================
	// opcodes
	localparam logic [2:0] OPC_SEL   = 3'h0;                   // select / reselect
	localparam logic [2:0] OPC_DISC  = 3'h1;                   // wait disconnect / disconnect
	localparam logic [2:0] OPC_WAIT  = 3'h2;                   // wait reselect / wait select
	localparam logic [2:0] OPC_SET   = 3'h3;
	localparam logic [2:0] OPC_CLR   = 3'h4;
	localparam logic [2:0] OPC_RW_LO = 3'h5;                   // 5..7 belong to read/write class

	// ============================================================
	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [7:0]  RST_BYTE = 8'h00;

	// ============================================================
	// controller states
	typedef enum logic [7:0] {
		ST_IDLE   = 8'h01,
		ST_TBL    = 8'h02,
		ST_BFREE  = 8'h04,
		ST_ARB    = 8'h08,
		ST_SELN   = 8'h10,
		ST_WSEL   = 8'h20,
		ST_WRESEL = 8'h40,
		ST_WDISC  = 8'h80
	} sio_state_e;
endpackage : sio_pkg
`default_nettype wire

//--- rtl/sio_io_unit.sv
`default_nettype none
module sio_io_unit (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// message logic: disconnect or command complete received
	input  wire logic        msg_done,
	// table fetch port
	output logic             mem_req,
	output logic      [31:0] mem_addr,
	input  wire logic        mem_ack,
	input  wire logic [31:0] mem_rdata,
	// bus pins, active low, open drain
	input  wire logic        bsy_n_i,
	output logic             bsy_n_o,
	output logic             bsy_n_oe,
	input  wire logic        sel_n_i,
	output logic             sel_n_o,
	output logic             sel_n_oe,
	input  wire logic        io_n_i,
	output logic             io_n_o,
	output logic             io_n_oe,
	output logic             atn_n_o,
	output logic             atn_n_oe,
	output logic             ack_n_o,
	output logic             ack_n_oe,
	input  wire logic [7:0]  db_n_i,
	output logic      [7:0]  db_n_o,
	output logic      [7:0]  db_n_oe,
	// differential driver direction controls
	output logic             ctl_dir,
	output logic             data_dir,
	// status to the rest of the processor
	output logic             alu_carry,
	output logic             exec_done
);
	// ============================================================
	// state record
	typedef struct packed {
		sio_pkg::sio_state_e state;          // controller state
		logic [10:0] pin_s1;                 // first synchroniser stage
		logic [10:0] pin_s2;                 // second synchroniser stage
		logic [31:0] cmd;                    // first instruction word
		logic [31:0] nxt;                    // alternate address word
		logic [31:0] ip;                     // instruction pointer
		logic [31:0] data_structure_base_register;                    // data structure base
		logic [7:0]  own_id;                 // own id mask
		logic [7:0]  sync_transfer_register;                  // sync offset/period
		logic [7:0]  dest;                   // destination id mask
		logic        target;                 // role: 1 target
		logic        latch_atn;              // output latch atn
		logic        latch_ack;              // output latch ack
		logic        carry;                  // alu carry
		logic        signal_process_flag;                   // signal process flag
		logic        done_flag;              // sticky done
		logic        rw_flag;                // read/write class seen
		logic        ill_flag;               // not an i/o instruction
		logic        msg_seen;               // qualifying message latched
		logic        sel_atn;                // atn during selection
		logic [7:0]  cnt;                    // delay counter
		logic        bsy_oe;
		logic        sel_oe;
		logic        io_oe;
		logic        atn_oe;
		logic        ack_oe;
		logic [7:0]  db_oe;
		logic        lvl;                    // driven level, always asserted low
		logic        ctl_dir;
		logic        data_dir;
		logic        mem_req;
		logic [31:0] mem_addr;
		logic [31:0] rdata;
		logic        exec_done;
	} sio_state_s;

	sio_state_s s;                        // current state
	sio_state_s next_s;                   // next state

	// ============================================================
	// helpers
	// sign extend a 24-bit offset
	function automatic logic [31:0] sio_sext24(input logic [23:0] v);
		sio_sext24 = {{8{v[23]}}, v};
	endfunction : sio_sext24

	// mask of ids above the highest own id bit
	function automatic logic [7:0] sio_above(input logic [7:0] id);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			if (id[i]) begin
				break;
			end
			m[i] = 1'b1;
		end
		sio_above = m;
	endfunction : sio_above

	// state that runs an opcode once parameters are known
	function automatic sio_pkg::sio_state_e sio_op_state(input logic [2:0] opc,
		input logic tgt);
		sio_op_state = sio_pkg::ST_IDLE;
		if (opc == sio_pkg::OPC_SEL) begin
			sio_op_state = sio_pkg::ST_BFREE;
		end else if (opc == sio_pkg::OPC_DISC && !tgt) begin
			sio_op_state = sio_pkg::ST_WDISC;
		end else if (opc == sio_pkg::OPC_WAIT) begin
			sio_op_state = tgt ? sio_pkg::ST_WSEL : sio_pkg::ST_WRESEL;
		end
	endfunction : sio_op_state

	// ============================================================
	// next state logic
	always_comb begin
		logic        bsy_a;
		logic        sel_a;
		logic        io_a;
		logic [7:0]  db_a;
		logic        bus_free;
		logic        sel_hit;
		logic        signal_process_flag_set;
		logic [2:0]  opc;
		logic [31:0] alt;
		logic        jump_alt;
		logic        finish;
		bsy_a    = ~s.pin_s2[0];
		sel_a    = ~s.pin_s2[1];
		io_a     = ~s.pin_s2[2];
		db_a     = ~s.pin_s2[10:3];
		bus_free = ~bsy_a & ~sel_a;
		// someone selects us: our id on the bus with sel, not our own sel
		sel_hit  = sel_a & ~s.sel_oe & (|(db_a & s.own_id));
		opc      = s.cmd[sio_pkg::CMD_OPC_HI:sio_pkg::CMD_OPC_LO];
		// alternate target, relative or absolute
		alt      = s.cmd[sio_pkg::CMD_REL_BIT] ?
			s.ip + sio_sext24(s.nxt[23:0]) : s.nxt;
		signal_process_flag_set = reg_wr && reg_addr == sio_pkg::OFS_INTERRUPT_STATUS_REGISTER &&
			reg_wdata[sio_pkg::INTERRUPT_STATUS_REGISTER_SIGNAL_PROCESS_FLAG_BIT];
		jump_alt = 1'b0;
		finish   = 1'b0;
		next_s   = s;
		next_s.pin_s1    = {db_n_i, io_n_i, sel_n_i, bsy_n_i};
		next_s.pin_s2    = s.pin_s1;
		next_s.exec_done = 1'b0;
		next_s.rdata     = 32'h0000_0000;
		next_s.lvl       = 1'b0;
		if (msg_done) begin
			next_s.msg_seen = 1'b1;
		end

		// register writes
		if (reg_wr) begin
			if (reg_addr == sio_pkg::OFS_CMD) begin
				next_s.cmd = reg_wdata;
			end else if (reg_addr == sio_pkg::OFS_NXT) begin
				next_s.nxt = reg_wdata;
			end else if (reg_addr == sio_pkg::OFS_IP) begin
				next_s.ip = reg_wdata;
			end else if (reg_addr == sio_pkg::OFS_DSA) begin
				next_s.data_structure_base_register = reg_wdata;
			end else if (reg_addr == sio_pkg::OFS_OWNID) begin
				next_s.own_id = reg_wdata[7:0];
			end else if (reg_addr == sio_pkg::OFS_SYNC_TRANSFER_REGISTER) begin
				next_s.sync_transfer_register = reg_wdata[7:0];
			end else if (reg_addr == sio_pkg::OFS_CTL0) begin
				next_s.target = reg_wdata[sio_pkg::CTL0_TGT_BIT];
			end else if (reg_addr == sio_pkg::OFS_LATCH) begin
				next_s.latch_atn = reg_wdata[sio_pkg::LATCH_ATN_BIT];
				next_s.latch_ack = reg_wdata[sio_pkg::LATCH_ACK_BIT];
			end else if (reg_addr == sio_pkg::OFS_INTERRUPT_STATUS_REGISTER) begin
				next_s.signal_process_flag = reg_wdata[sio_pkg::INTERRUPT_STATUS_REGISTER_SIGNAL_PROCESS_FLAG_BIT];
			end else if (reg_addr == sio_pkg::OFS_EXEC) begin
				// write one clears; hardware sets below win
				if (reg_wdata[sio_pkg::EXEC_DONE_BIT]) begin
					next_s.done_flag = 1'b0;
				end
				if (reg_wdata[sio_pkg::EXEC_RW_BIT]) begin
					next_s.rw_flag = 1'b0;
				end
				if (reg_wdata[sio_pkg::EXEC_ILL_BIT]) begin
					next_s.ill_flag = 1'b0;
				end
			end
		end

		// register reads, data stand one cycle later
		if (reg_rd) begin
			if (reg_addr == sio_pkg::OFS_CMD) begin
				next_s.rdata = s.cmd;
			end else if (reg_addr == sio_pkg::OFS_NXT) begin
				next_s.rdata = s.nxt;
			end else if (reg_addr == sio_pkg::OFS_IP) begin
				next_s.rdata = s.ip;
			end else if (reg_addr == sio_pkg::OFS_DSA) begin
				next_s.rdata = s.data_structure_base_register;
			end else if (reg_addr == sio_pkg::OFS_OWNID) begin
				next_s.rdata = {24'h00_0000, s.own_id};
			end else if (reg_addr == sio_pkg::OFS_SYNC_TRANSFER_REGISTER) begin
				next_s.rdata = {24'h00_0000, s.sync_transfer_register};
			end else if (reg_addr == sio_pkg::OFS_CTL0) begin
				next_s.rdata[sio_pkg::CTL0_TGT_BIT] = s.target;
			end else if (reg_addr == sio_pkg::OFS_LATCH) begin
				next_s.rdata[sio_pkg::LATCH_ATN_BIT] = s.latch_atn;
				next_s.rdata[sio_pkg::LATCH_ACK_BIT] = s.latch_ack;
			end else if (reg_addr == sio_pkg::OFS_INTERRUPT_STATUS_REGISTER) begin
				next_s.rdata[sio_pkg::INTERRUPT_STATUS_REGISTER_SIGNAL_PROCESS_FLAG_BIT] = s.signal_process_flag;
			end else if (reg_addr == sio_pkg::OFS_EXEC) begin
				next_s.rdata[sio_pkg::EXEC_DONE_BIT]  = s.done_flag;
				next_s.rdata[sio_pkg::EXEC_RW_BIT]    = s.rw_flag;
				next_s.rdata[sio_pkg::EXEC_ILL_BIT]   = s.ill_flag;
				next_s.rdata[sio_pkg::EXEC_BUSY_BIT]  = s.state != sio_pkg::ST_IDLE;
				next_s.rdata[sio_pkg::EXEC_CARRY_BIT] = s.carry;
			end
		end

		// controller
		case (s.state)
			sio_pkg::ST_IDLE: begin
				if (reg_wr && reg_addr == sio_pkg::OFS_EXEC &&
					reg_wdata[sio_pkg::EXEC_GO_BIT]) begin
					next_s.dest = s.cmd[23:16];
					next_s.cnt  = 8'h00;
					if (s.cmd[sio_pkg::CMD_TYPE_HI -: 2] != sio_pkg::TYPE_IO) begin
						next_s.ill_flag = 1'b1;
						finish = 1'b1;
					end else if (opc >= sio_pkg::OPC_RW_LO) begin
						// handed over to the read/write class
						next_s.rw_flag = 1'b1;
						finish = 1'b1;
					end else if (opc == sio_pkg::OPC_SET || opc == sio_pkg::OPC_CLR) begin
						// latch, role and carry follow the selected bits
						if (s.cmd[sio_pkg::CMD_ATN_BIT]) begin
							next_s.latch_atn = opc == sio_pkg::OPC_SET;
						end
						if (s.cmd[sio_pkg::CMD_ACK_BIT]) begin
							next_s.latch_ack = opc == sio_pkg::OPC_SET;
						end
						if (s.cmd[sio_pkg::CMD_TGT_BIT]) begin
							next_s.target = opc == sio_pkg::OPC_SET;
						end
						if (s.cmd[sio_pkg::CMD_CARRY_BIT]) begin
							next_s.carry = opc == sio_pkg::OPC_SET;
						end
						finish = 1'b1;
					end else if (opc == sio_pkg::OPC_DISC && s.target) begin
						// let go of every line and both direction controls
						next_s.bsy_oe    = 1'b0;
						next_s.sel_oe    = 1'b0;
						next_s.io_oe     = 1'b0;
						next_s.db_oe     = 8'h00;
						next_s.sel_atn   = 1'b0;
						next_s.latch_atn = 1'b0;
						next_s.latch_ack = 1'b0;
						finish = 1'b1;
					end else if (s.cmd[sio_pkg::CMD_TBL_BIT]) begin
						// entry address: base plus signed offset
						next_s.mem_req  = 1'b1;
						next_s.mem_addr = s.data_structure_base_register + sio_sext24(s.cmd[23:0]);
						next_s.state    = sio_pkg::ST_TBL;
					end else begin
						next_s.state = sio_op_state(opc, s.target);
					end
				end
			end
			sio_pkg::ST_TBL: begin
				if (mem_ack) begin
					// entry bytes: zero, id, offset/period, zero
					next_s.dest    = mem_rdata[23:16];
					next_s.sync_transfer_register   = mem_rdata[15:8];
					next_s.mem_req = 1'b0;
					next_s.state   = sio_op_state(opc, s.target);
				end
			end
			sio_pkg::ST_BFREE: begin
				if (sel_hit) begin
					jump_alt = 1'b1;
					next_s.target = ~io_a;
				end else if (bus_free) begin
					next_s.cnt = s.cnt + 8'h01;
					if (s.cnt == sio_pkg::BUS_FREE_CYC - 8'h01) begin
						// arbitrate with our own id
						next_s.bsy_oe = 1'b1;
						next_s.db_oe  = s.own_id;
						next_s.cnt    = 8'h00;
						next_s.state  = sio_pkg::ST_ARB;
					end
				end else begin
					next_s.cnt = 8'h00;
				end
			end
			sio_pkg::ST_ARB: begin
				next_s.cnt = s.cnt + 8'h01;
				if (sel_hit) begin
					next_s.bsy_oe = 1'b0;
					next_s.db_oe  = 8'h00;
					jump_alt = 1'b1;
					next_s.target = ~io_a;
				end else if (s.cnt == sio_pkg::ARB_CYC - 8'h01) begin
					if (sel_a || (|(db_a & sio_above(s.own_id)))) begin
						// lost: drop off and try the next bus free, no status
						next_s.bsy_oe = 1'b0;
						next_s.db_oe  = 8'h00;
						next_s.cnt    = 8'h00;
						next_s.state  = sio_pkg::ST_BFREE;
					end else begin
						// won: address the destination
						next_s.sel_oe  = 1'b1;
						next_s.db_oe   = s.own_id | s.dest;
						next_s.io_oe   = s.target;
						next_s.sel_atn = ~s.target & s.cmd[sio_pkg::CMD_SATN_BIT];
						next_s.cnt     = 8'h00;
						next_s.state   = sio_pkg::ST_SELN;
					end
				end
			end
			sio_pkg::ST_SELN: begin
				if (s.cnt != sio_pkg::SETTLE_CYC) begin
					next_s.cnt = s.cnt + 8'h01;
				end
				if (s.cnt == sio_pkg::SETTLE_CYC - 8'h01) begin
					next_s.bsy_oe = 1'b0;
				end else if (s.cnt == sio_pkg::SETTLE_CYC && bsy_a) begin
					// destination answered: connected, continue at pointer
					next_s.sel_oe  = 1'b0;
					next_s.db_oe   = 8'h00;
					next_s.bsy_oe  = s.target;
					next_s.sel_atn = 1'b0;
					next_s.latch_atn = s.latch_atn | s.sel_atn;
					finish = 1'b1;
				end
			end
			sio_pkg::ST_WSEL: begin
				if (s.signal_process_flag) begin
					next_s.signal_process_flag = signal_process_flag_set;
					jump_alt = 1'b1;
				end else if (sel_hit) begin
					if (io_a) begin
						jump_alt = 1'b1;
						next_s.target = 1'b0;
					end else begin
						finish = 1'b1;
					end
				end
			end
			sio_pkg::ST_WRESEL: begin
				if (s.signal_process_flag) begin
					next_s.signal_process_flag = signal_process_flag_set;
					jump_alt = 1'b1;
				end else if (sel_hit) begin
					if (io_a) begin
						finish = 1'b1;
					end else begin
						jump_alt = 1'b1;
						next_s.target = 1'b1;
					end
				end
			end
			sio_pkg::ST_WDISC: begin
				if (s.msg_seen && bus_free) begin
					next_s.cnt = s.cnt + 8'h01;
					if (s.cnt == sio_pkg::BUS_FREE_CYC - 8'h01) begin
						next_s.msg_seen = msg_done;
						finish = 1'b1;
					end
				end else begin
					next_s.cnt = 8'h00;
				end
			end
			default: begin
				next_s.state = sio_pkg::ST_IDLE;
			end
		endcase

		// completion, with or without the alternate jump
		if (jump_alt) begin
			next_s.ip = alt;
			finish = 1'b1;
		end
		if (finish) begin
			next_s.state     = sio_pkg::ST_IDLE;
			next_s.done_flag = 1'b1;
			next_s.exec_done = 1'b1;
		end

		// initiator lines only reach the bus in initiator role
		next_s.atn_oe   = (next_s.latch_atn & ~next_s.target) | next_s.sel_atn;
		next_s.ack_oe   = next_s.latch_ack & ~next_s.target;
		next_s.ctl_dir  = next_s.bsy_oe | next_s.sel_oe | next_s.io_oe |
			next_s.atn_oe | next_s.ack_oe;
		next_s.data_dir = |next_s.db_oe;
	end

	// ============================================================
	// state register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s          <= '0;
			s.state    <= sio_pkg::ST_IDLE;
			s.pin_s1   <= 11'h7ff;
			s.pin_s2   <= 11'h7ff;
			s.cmd      <= sio_pkg::RST_WORD;
			s.nxt      <= sio_pkg::RST_WORD;
			s.ip       <= sio_pkg::RST_WORD;
			s.data_structure_base_register      <= sio_pkg::RST_WORD;
			s.own_id   <= sio_pkg::RST_BYTE;
			s.sync_transfer_register    <= sio_pkg::RST_BYTE;
		end else begin
			s <= next_s;
		end
	end

	// ============================================================
	// outputs, all straight from the state register
	assign reg_rdata = s.rdata;
	assign mem_req   = s.mem_req;
	assign mem_addr  = s.mem_addr;
	assign bsy_n_o   = s.lvl;
	assign bsy_n_oe  = s.bsy_oe;
	assign sel_n_o   = s.lvl;
	assign sel_n_oe  = s.sel_oe;
	assign io_n_o    = s.lvl;
	assign io_n_oe   = s.io_oe;
	assign atn_n_o   = s.lvl;
	assign atn_n_oe  = s.atn_oe;
	assign ack_n_o   = s.lvl;
	assign ack_n_oe  = s.ack_oe;
	assign db_n_o    = {8{s.lvl}};
	assign db_n_oe   = s.db_oe;
	assign ctl_dir   = s.ctl_dir;
	assign data_dir  = s.data_dir;
	assign alu_carry = s.carry;
	assign exec_done = s.exec_done;
endmodule : sio_io_unit
`default_nettype wire

//--- bench/sio_io_unit_asserts.sv
`default_nettype none
// ====================
// port checks of the i/o unit
module sio_io_unit_asserts (
	input wire logic        core_clk, rstn, reg_wr, mem_req, mem_ack, exec_done,
	input wire logic        alu_carry, bsy_n_oe, sel_n_oe, atn_n_oe, data_dir,
	input wire logic [7:0]  reg_addr, db_n_oe,
	input wire logic [31:0] reg_wdata, mem_addr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	logic [31:0] cmd; // instruction word
	logic [7:0]  own; // own bus id
	// shadow of the two registers the checks need
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn) {cmd, own} <= '0;
		else if (reg_wr && reg_addr == 8'h00) cmd <= reg_wdata;
		else if (reg_wr && reg_addr == 8'h10) own <= reg_wdata[7:0];
	// go strobe for an i/o class word
	sequence s_go;
		reg_wr && reg_addr == 8'h24 && reg_wdata[0] && cmd[31:30] == 2'h1;
	endsequence
	a_set_carry: assert property (s_go ##0 (cmd[29:27] == 3 && cmd[10]) |=> alu_carry)
		else $error("carry not set");
	a_clr_carry: assert property (s_go ##0 (cmd[29:27] == 4 && cmd[10]) |=> !alu_carry)
		else $error("carry not cleared");
	a_rw_skip: assert property (s_go ##0 (cmd[29] && cmd[28:27] != 0) |=> exec_done
		&& $stable(alu_carry)) else $error("rw word acted");
	a_fetch_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("fetch dropped");
	a_arb_own: assert property (bsy_n_oe && !sel_n_oe && |db_n_oe |-> db_n_oe == own)
		else $error("arbitration id");
	a_win_hold: assert property ($rose(sel_n_oe) |-> bsy_n_oe && (db_n_oe & own) == own)
		else $error("selection start");
	a_sel_atn: assert property ($rose(sel_n_oe) && cmd[24] |-> atn_n_oe)
		else $error("atn missing");
	a_data_dir: assert property (|db_n_oe |-> data_dir)
		else $error("data direction");
endmodule : sio_io_unit_asserts
bind sio_io_unit sio_io_unit_asserts sio_io_unit_asserts_i (.*);
`default_nettype wire

//--- bench/sio_bus_model.sv
`default_nettype none
// ====================
// far side: one target device and the table memory
module sio_bus_model (
	input wire logic        core_clk, bsy_n_oe, sel_n_oe, io_n_oe, mem_req, free, call_io,
	input wire logic [7:0]  db_n_oe, peer_id, call_id,
	input wire logic [31:0] entry,
	output logic            bsy_n_i, sel_n_i, io_n_i,
	output logic     [7:0]  db_n_i,
	output logic            mem_ack = 0,
	output logic     [31:0] mem_rdata = 0
);
	timeunit 1ns;
	timeprecision 100ps;
	logic busy = 0; // target holds bsy
	int   lat = 0;  // cycles a fetch has waited
	// wired lines, low while any party drives
	assign bsy_n_i = !(bsy_n_oe || busy);
	// a far device calling us puts both ids on data with sel, io for a reselection
	assign sel_n_i = !(sel_n_oe || |call_id);
	assign io_n_i = !(io_n_oe || call_io);
	assign db_n_i = ~(db_n_oe | call_id);
	always @(posedge core_clk) begin
		// take bsy once selected by id and the arbiter let go
		busy <= !free && (busy || sel_n_oe && !bsy_n_oe && |(db_n_oe & peer_id));
		lat <= mem_req && !mem_ack ? lat + 1 : 0;
		mem_ack <= mem_req && !mem_ack && lat == 2;
		// entry word on the answer, a changing pattern otherwise
		mem_rdata <= mem_req && !mem_ack && lat == 2 ? entry : ~mem_rdata;
	end
endmodule : sio_bus_model
`default_nettype wire

//--- bench/sio_io_unit_test.sv
`default_nettype none
// ====================
// bench of the i/o unit
module sio_io_unit_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, msg_done = 0, free = 0, call_io = 0;
	logic [7:0] reg_addr = 0, peer_id = 8'h04, call_id = 0, db_n_i, db_n_o, db_n_oe;
	logic [31:0] reg_wdata = 0, entry = 32'h00045a00, reg_rdata, mem_addr, mem_rdata, r;
	logic mem_req, mem_ack, bsy_n_i, bsy_n_o, bsy_n_oe, sel_n_i, sel_n_o, sel_n_oe, io_n_i;
	logic io_n_o, io_n_oe, atn_n_o, atn_n_oe, ack_n_o, ack_n_oe, ctl_dir, data_dir;
	logic alu_carry, exec_done;
	int err_total = 0, check_count = 0, seed = 12, cyc = 0, n, ma, mk, mt, mc;
	sio_io_unit sio_io_unit_i (.*);
	sio_bus_model sio_bus_model_i (.*);
	always #12.5 core_clk = !core_clk;
	// cut a hang short
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge core_clk);
		reg_wr <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge core_clk);
		reg_rd <= 0;
		@(negedge core_clk);
		chk(reg_rdata, exp);
	endtask : rd
	// load both words, start, count cycles to the end pulse
	task automatic run(input logic [31:0] c, nx);
		wr(8'h00, c);
		wr(8'h04, nx);
		wr(8'h24, 1);
		n = 0;
		while (exec_done !== 1'b1) begin
			@(negedge core_clk);
			n++;
		end
		@(posedge core_clk);
	endtask : run
	// a far device (ids 5 and 2) calls us during the instruction, then lets go
	task automatic take(input logic [31:0] c, nx, ipx, input logic io, tg);
		@(posedge core_clk);
		{call_id, call_io} <= {8'h24, io};
		run(c, nx);
		{call_id, call_io} <= 9'h000;
		rd(8'h08, ipx);
		rd(8'h18, tg);
	endtask : take
	task automatic test_done;
		if (err_total == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done
	initial begin
		repeat (3) @(posedge core_clk);
		rstn <= 1;
		rd(8'h1c, 0);
		rd(8'h30, 0);
		{ma, mk, mt, mc} = 0;
		repeat (12) begin
			r = $random(seed) & 32'h649;
			run({2'h1, r[0] ? 3'h3 : 3'h4, 27'h0} | r & 32'h648, 0);
			ma = r[3] ? r[0] : ma;
			mk = r[6] ? r[0] : mk;
			mt = r[9] ? r[0] : mt;
			mc = r[10] ? r[0] : mc;
			rd(8'h1c, mk * 64 + ma * 8);
			rd(8'h18, mt);
			chk(alu_carry, mc);
			chk({ack_n_oe, atn_n_oe}, mt ? 0 : mk * 2 + ma);
		end
		for (int o = 5; o < 8; o++) begin
			run({2'h1, 3'(o), 27'h0}, 0);
			rd(8'h24, 3 + mc * 16);
		end
		run(32'h58000208, 0);
		run(32'h48000000, 0);
		rd(8'h1c, 0);
		chk({ctl_dir, data_dir, bsy_n_oe, sel_n_oe, io_n_oe, atn_n_oe, ack_n_oe, db_n_oe}, 0);
		chk({bsy_n_o, sel_n_o, io_n_o, atn_n_o, ack_n_o, db_n_o}, 0);
		run(32'h60000600, 0);
		wr(8'h10, 32'h20);
		wr(8'h08, 32'h100);
		run(32'h41040000, 32'h8000);
		rd(8'h08, 32'h100);
		chk(atn_n_oe, 1);
		fork
			run(32'h48000000, 0);
			begin
				repeat (30) @(posedge core_clk);
				msg_done <= 1;
				@(posedge core_clk);
				msg_done <= 0;
				repeat (20) @(posedge core_clk);
				free <= 1;
			end
		join
		chk(n > 61, 1);
		wr(8'h0c, 32'h1000);
		fork
			run(32'h56fffff8, 32'h40);
			begin
				@(posedge mem_req);
				@(negedge core_clk);
				chk(mem_addr, 32'hff8);
				repeat (20) @(posedge core_clk);
				wr(8'h20, 32'h20);
			end
		join
		rd(8'h08, 32'h140);
		rd(8'h14, 32'h5a);
		rd(8'h20, 0);
		take(32'h50000000, 32'h200, 32'h140, 1, 0);
		take(32'h50000000, 32'h200, 32'h200, 0, 1);
		take(32'h50000000, 32'h300, 32'h200, 0, 1);
		take(32'h50000000, 32'h300, 32'h300, 1, 0);
		take(32'h40000000, 32'h400, 32'h400, 0, 1);
		take(32'h44000000, 32'h10, 32'h410, 1, 0);
		test_done();
	end
endmodule : sio_io_unit_test
`default_nettype wire
